// ===== rtl/btc_defines.svh
// Constants shared by both ends of the bus cycle termination link
`ifndef BTC_DEFINES_SVH
`define BTC_DEFINES_SVH
// ========================================
// Widths
`define BTC_ADDR_W 24
`define BTC_DATA_W 16
`define BTC_HOLD_W 4
// ========================================
// Least stop-request hold after fault release, in clock cycles
`define BTC_STOP_HOLD_MIN 4'h1
`endif

// ===== rtl/btc_pkg.sv
// Types shared by both ends of the bus cycle termination link
package btc_pkg;
    // ========================================
    // Termination kinds
    typedef enum logic [1:0] {
        BTC_NORMAL = 2'h0,
        BTC_HALT   = 2'h1,
        BTC_BUSERR = 2'h2,
        BTC_RERUN  = 2'h3
    } btc_kind_t;
    // ========================================
    // Processor end states
    typedef enum logic [2:0] {
        BTC_C_IDLE = 3'h0,
        BTC_C_RUN  = 3'h1,
        BTC_C_TERM = 3'h2,
        BTC_C_REL  = 3'h3,
        BTC_C_HALT = 3'h4
    } btc_cst_t;
    // ========================================
    // External end states
    typedef enum logic [2:0] {
        BTC_E_IDLE = 3'h0,
        BTC_E_WAIT = 3'h1,
        BTC_E_LATE = 3'h2,
        BTC_E_END  = 3'h3,
        BTC_E_HOLD = 3'h4
    } btc_est_t;
endpackage : btc_pkg

// ===== rtl/btc_if.sv
// Pin-level link between the processor end and the external end
`timescale 1ns/1ps
`default_nettype none
`include "btc_defines.svh"
interface btc_if;
    // Processor driven
    logic                   strobe_n;  // Cycle in progress, low
    logic                   write_n;   // Write cycle, low
    logic                   rmw;       // Read-modify-write cycle
    logic [`BTC_ADDR_W-1:0] addr;      // Address lines
    logic                   addr_oe;   // Address lines driven
    logic [`BTC_DATA_W-1:0] wdata;     // Write data lines
    logic                   data_oe;   // Write data lines driven
    // External driven
    logic                   transfer_ack_n;  // Transfer acknowledge, low
    logic                   bus_fault_n;     // Bus fault, low
    logic                   stop_req_n;      // Stop request, low
    logic [`BTC_DATA_W-1:0] rdata;           // Read data lines
    modport cpu (output strobe_n, write_n, rmw, addr, addr_oe, wdata,
                 data_oe, input transfer_ack_n, bus_fault_n, stop_req_n,
                 rdata);
    modport ext (input strobe_n, write_n, rmw, addr, addr_oe, wdata,
                 data_oe, output transfer_ack_n, bus_fault_n, stop_req_n,
                 rdata);
endinterface : btc_if
`default_nettype wire

// ===== rtl/btc_cpu_end.sv
// Processor end: runs bus cycles and decides how each one terminates
// How it works
// - Partner changes inputs on rising clock edges
// - Acknowledge alone ends cycle normally, continue
// - Stop with or before acknowledge halts after
// - Fault without stop aborts cycle as error
// - Partner keeps fault until acknowledge is negated
// - Fault plus stop ends cycle for rerun
// - Partner holds stop at least one cycle past fault
// - Rerun repeats same address, data, direction
// - Fault plus stop on RMW gives error
// - Error exception starts once fault is negated
// - Stop seen: lines released, no new cycle
`timescale 1ns/1ps
`default_nettype none
`include "btc_defines.svh"
module btc_cpu_end
    import btc_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rstn,
    // Link to external logic
    btc_if.cpu                          bus,
    // Cycle request
    input  wire logic                   req_valid,
    input  wire logic                   req_write,
    input  wire logic                   req_rmw,
    input  wire logic [`BTC_ADDR_W-1:0] req_addr,
    input  wire logic [`BTC_DATA_W-1:0] req_wdata,
    output logic                        req_ready,
    // Cycle outcome
    output logic                        rsp_done,
    output logic [`BTC_DATA_W-1:0]      rsp_rdata,
    output logic                        rsp_bus_error,
    output logic                        rsp_rerun,
    output logic                        halted
);
    // ========================================
    // State
    btc_cst_t               st_q, st_d;        // Cycle state
    btc_kind_t              kind_q, kind_d;    // Chosen termination
    logic                   ack_q, fault_q;    // Sampled inputs, high true
    logic                   stop_q;            // Sampled stop request
    logic [`BTC_ADDR_W-1:0] addr_q, addr_d;    // Held address
    logic [`BTC_DATA_W-1:0] wdata_q, wdata_d;  // Held write data
    logic                   write_q, write_d;  // Held direction
    logic                   rmw_q, rmw_d;      // Held read-modify-write
    logic [`BTC_DATA_W-1:0] rdata_q, rdata_d;  // Captured read data
    logic                   done_q, done_d;    // Completion pulse
    logic                   err_q, err_d;      // Exception start pulse
    logic                   rerun_q, rerun_d;  // Rerun pulse
    logic                   on_bus;            // Cycle drives the bus

    // ========================================
    // Fault outcome: rerun only with stop and outside RMW cycles
    function automatic btc_kind_t fault_kind(input logic stop,
                                             input logic rmw);
        fault_kind = (stop && !rmw) ? BTC_RERUN : BTC_BUSERR;
    endfunction : fault_kind

    // ========================================
    // Outputs toward the link
    always_comb begin
        on_bus       = (st_q == BTC_C_RUN) || (st_q == BTC_C_TERM);
        bus.strobe_n = !on_bus;
        bus.write_n  = !(on_bus && write_q);
        bus.rmw      = on_bus && rmw_q;
        bus.addr     = addr_q;
        bus.wdata    = wdata_q;
        bus.addr_oe  = on_bus;
        bus.data_oe  = on_bus && write_q;
    end

    // Outputs toward the user
    always_comb begin
        req_ready     = (st_q == BTC_C_IDLE) && !stop_q;
        halted        = (st_q == BTC_C_HALT) ||
                        ((st_q == BTC_C_IDLE) && stop_q);
        rsp_done      = done_q;
        rsp_rdata     = rdata_q;
        rsp_bus_error = err_q;
        rsp_rerun     = rerun_q;
    end

    // ========================================
    // Next state
    always_comb begin
        st_d    = st_q;
        kind_d  = kind_q;
        addr_d  = addr_q;
        wdata_d = wdata_q;
        write_d = write_q;
        rmw_d   = rmw_q;
        rdata_d = rdata_q;
        done_d  = 1'b0;
        err_d   = 1'b0;
        rerun_d = 1'b0;
        case (st_q)
            BTC_C_IDLE: begin
                // New cycle only while stop is not seen
                if (req_valid && !stop_q) begin
                    addr_d  = req_addr;
                    wdata_d = req_wdata;
                    write_d = req_write;
                    rmw_d   = req_rmw;
                    kind_d  = BTC_NORMAL;
                    st_d    = BTC_C_RUN;
                end
            end
            BTC_C_RUN: begin
                // Decide from the inputs seen in the same state
                if (fault_q) begin
                    kind_d = fault_kind(stop_q, rmw_q);
                    st_d   = BTC_C_REL;
                end else if (ack_q) begin
                    rdata_d = bus.rdata;
                    kind_d  = stop_q ? BTC_HALT : BTC_NORMAL;
                    st_d    = BTC_C_TERM;
                end
            end
            BTC_C_TERM: begin
                // One more state for a fault that trails acknowledge
                if (fault_q) begin
                    kind_d = fault_kind(stop_q, rmw_q);
                end else if (stop_q && kind_q == BTC_NORMAL) begin
                    kind_d = BTC_HALT;
                end
                st_d = BTC_C_REL;
            end
            BTC_C_REL: begin
                // Bus released; wait for acknowledge and fault to drop
                if (!ack_q && !fault_q) begin
                    case (kind_q)
                        BTC_NORMAL: begin
                            done_d = 1'b1;
                            st_d   = BTC_C_IDLE;
                        end
                        BTC_HALT: begin
                            done_d = 1'b1;
                            st_d   = BTC_C_HALT;
                        end
                        BTC_BUSERR: begin
                            err_d = 1'b1;
                            st_d  = BTC_C_IDLE;
                        end
                        default: begin
                            rerun_d = 1'b1;
                            st_d    = stop_q ? BTC_C_HALT : BTC_C_RUN;
                        end
                    endcase
                end
            end
            BTC_C_HALT: begin
                // Lines stay released until stop is removed
                if (!stop_q) begin
                    st_d = (kind_q == BTC_RERUN) ? BTC_C_RUN
                                                 : BTC_C_IDLE;
                    kind_d = BTC_NORMAL;
                end
            end
            default: begin
                st_d = BTC_C_IDLE;
            end
        endcase
    end

    // ========================================
    // Registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q    <= BTC_C_IDLE;
            kind_q  <= BTC_NORMAL;
            ack_q   <= 1'b0;
            fault_q <= 1'b0;
            stop_q  <= 1'b0;
            addr_q  <= '0;
            wdata_q <= '0;
            write_q <= 1'b0;
            rmw_q   <= 1'b0;
            rdata_q <= '0;
            done_q  <= 1'b0;
            err_q   <= 1'b0;
            rerun_q <= 1'b0;
        end else begin
            st_q    <= st_d;
            kind_q  <= kind_d;
            ack_q   <= !bus.transfer_ack_n;
            fault_q <= !bus.bus_fault_n;
            stop_q  <= !bus.stop_req_n;
            addr_q  <= addr_d;
            wdata_q <= wdata_d;
            write_q <= write_d;
            rmw_q   <= rmw_d;
            rdata_q <= rdata_d;
            done_q  <= done_d;
            err_q   <= err_d;
            rerun_q <= rerun_d;
        end
    end
endmodule : btc_cpu_end
`default_nettype wire

// ===== rtl/btc_ext_end.sv
// External end: acknowledges processor cycles with a chosen termination
`timescale 1ns/1ps
`default_nettype none
`include "btc_defines.svh"
module btc_ext_end
    import btc_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rstn,
    // Link to the processor
    btc_if.ext                          bus,
    // Termination command
    input  wire logic                   cmd_valid,
    input  wire btc_kind_t              cmd_kind,
    input  wire logic                   cmd_late,
    input  wire logic [`BTC_HOLD_W-1:0] cmd_hold,
    input  wire logic [`BTC_DATA_W-1:0] cmd_rdata,
    output logic                        cmd_ready,
    // Observed cycle
    output logic                        obs_valid,
    output logic [`BTC_ADDR_W-1:0]      obs_addr,
    output logic [`BTC_DATA_W-1:0]      obs_wdata,
    output logic                        obs_write
);
    // ========================================
    // State
    btc_est_t               st_q, st_d;        // Sequencer state
    btc_kind_t              kind_q, kind_d;    // Termination to give
    logic                   late_q, late_d;    // Fault trails acknowledge
    logic [`BTC_HOLD_W-1:0] hold_q, hold_d;    // Stop hold count
    logic [`BTC_DATA_W-1:0] rd_q, rd_d;        // Read data to return
    logic                   ack_q, ack_d;      // Acknowledge, high true
    logic                   flt_q, flt_d;      // Fault, high true
    logic                   stp_q, stp_d;      // Stop, high true
    logic                   ov_q, ov_d;        // Observation pulse
    logic [`BTC_ADDR_W-1:0] oa_q, oa_d;        // Observed address
    logic [`BTC_DATA_W-1:0] ow_q, ow_d;        // Observed write data
    logic                   owr_q, owr_d;      // Observed direction
    logic                   want_flt;          // Kind carries a fault
    logic                   want_stp;          // Kind carries a stop

    // ========================================
    // Pins come straight from flops so they move on rising edges
    always_comb begin
        bus.transfer_ack_n = !ack_q;
        bus.bus_fault_n    = !flt_q;
        bus.stop_req_n     = !stp_q;
        bus.rdata          = rd_q;
        cmd_ready          = (st_q == BTC_E_IDLE);
        obs_valid          = ov_q;
        obs_addr           = oa_q;
        obs_wdata          = ow_q;
        obs_write          = owr_q;
        want_flt           = (kind_q == BTC_BUSERR) || (kind_q == BTC_RERUN);
        want_stp           = (kind_q == BTC_HALT) || (kind_q == BTC_RERUN);
    end

    // ========================================
    // Next state
    always_comb begin
        st_d   = st_q;
        kind_d = kind_q;
        late_d = late_q;
        hold_d = hold_q;
        rd_d   = rd_q;
        ack_d  = ack_q;
        flt_d  = flt_q;
        stp_d  = stp_q;
        ov_d   = 1'b0;
        oa_d   = oa_q;
        ow_d   = ow_q;
        owr_d  = owr_q;
        case (st_q)
            BTC_E_IDLE: begin
                // Take the next termination command
                if (cmd_valid) begin
                    kind_d = cmd_kind;
                    late_d = cmd_late;
                    rd_d   = cmd_rdata;
                    hold_d = (cmd_hold < `BTC_STOP_HOLD_MIN)
                             ? `BTC_STOP_HOLD_MIN : cmd_hold;
                    st_d   = BTC_E_WAIT;
                end
            end
            BTC_E_WAIT: begin
                // Cycle seen: drive acknowledge, stop and any early fault on one edge
                if (!bus.strobe_n) begin
                    ov_d  = 1'b1;
                    oa_d  = bus.addr;
                    ow_d  = bus.wdata;
                    owr_d = !bus.write_n;
                    ack_d = 1'b1;
                    stp_d = want_stp;
                    flt_d = want_flt && !late_q;
                    st_d  = (want_flt && late_q) ? BTC_E_LATE : BTC_E_END;
                end
            end
            BTC_E_LATE: begin
                // Fault one cycle after acknowledge
                flt_d = 1'b1;
                st_d  = BTC_E_END;
            end
            BTC_E_END: begin
                // Release acknowledge and fault together
                if (bus.strobe_n) begin
                    ack_d = 1'b0;
                    flt_d = 1'b0;
                    st_d  = stp_q ? BTC_E_HOLD : BTC_E_IDLE;
                end
            end
            BTC_E_HOLD: begin
                // Stop outlives the fault by the hold count
                if (hold_q == `BTC_STOP_HOLD_MIN) begin
                    stp_d = 1'b0;
                    st_d  = BTC_E_IDLE;
                end else begin
                    hold_d = hold_q - `BTC_STOP_HOLD_MIN;
                end
            end
            default: begin
                st_d = BTC_E_IDLE;
            end
        endcase
    end

    // ========================================
    // Registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q   <= BTC_E_IDLE;
            kind_q <= BTC_NORMAL;
            late_q <= 1'b0;
            hold_q <= `BTC_STOP_HOLD_MIN;
            rd_q   <= '0;
            ack_q  <= 1'b0;
            flt_q  <= 1'b0;
            stp_q  <= 1'b0;
            ov_q   <= 1'b0;
            oa_q   <= '0;
            ow_q   <= '0;
            owr_q  <= 1'b0;
        end else begin
            st_q   <= st_d;
            kind_q <= kind_d;
            late_q <= late_d;
            hold_q <= hold_d;
            rd_q   <= rd_d;
            ack_q  <= ack_d;
            flt_q  <= flt_d;
            stp_q  <= stp_d;
            ov_q   <= ov_d;
            oa_q   <= oa_d;
            ow_q   <= ow_d;
            owr_q  <= owr_d;
        end
    end
endmodule : btc_ext_end
`default_nettype wire

// ===== testbench/btc_props.sv
// Pin-level assertions watching the link between the two ends
`timescale 1ns/1ps
`default_nettype none
`include "btc_defines.svh"
module btc_props (
    // Clock and reset
    input wire logic                   clk,
    input wire logic                   rstn,
    // Processor driven pins
    input wire logic                   strobe_n,
    input wire logic                   write_n,
    input wire logic                   rmw,
    input wire logic [`BTC_ADDR_W-1:0] addr,
    input wire logic                   addr_oe,
    input wire logic [`BTC_DATA_W-1:0] wdata,
    input wire logic                   data_oe,
    // External driven pins
    input wire logic                   transfer_ack_n,
    input wire logic                   bus_fault_n,
    input wire logic                   stop_req_n,
    input wire logic [`BTC_DATA_W-1:0] rdata
);
    // ========================================
    // Helper state
    logic [`BTC_ADDR_W-1:0] cyc_addr_q;     // Address of last started cycle
    logic [`BTC_DATA_W-1:0] cyc_wdata_q;    // Write data of that cycle
    logic                   cyc_write_n_q;  // Direction of that cycle
    logic                   cyc_rmw_q;      // That cycle was read-modify-write
    logic                   rerun_pend_q;   // Fault and stop ended it
    // Remembers each cycle start and whether a repeat is owed
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cyc_addr_q    <= '0;
            cyc_wdata_q   <= '0;
            cyc_write_n_q <= 1'b1;
            cyc_rmw_q     <= 1'b0;
            rerun_pend_q  <= 1'b0;
        end else if ($fell(strobe_n)) begin
            cyc_addr_q    <= addr;
            cyc_wdata_q   <= wdata;
            cyc_write_n_q <= write_n;
            cyc_rmw_q     <= rmw;
            rerun_pend_q  <= 1'b0;
        end else if ($rose(bus_fault_n) && !stop_req_n && !cyc_rmw_q) begin
            rerun_pend_q  <= 1'b1;
        end
    end
    // ========================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Stop request taken away by the external end
    sequence s_stop_drop;
        $rose(stop_req_n);
    endsequence
    sequence s_rerun_start;
        $fell(strobe_n) && rerun_pend_q;
    endsequence
    sequence s_stop_release;
        $rose(stop_req_n) && rerun_pend_q;
    endsequence
    chk_lines_released: assert property (
        strobe_n |-> !addr_oe && !data_oe)
        else $error("address or data driven outside a cycle");
    chk_data_on_write: assert property (
        data_oe |-> !write_n && !strobe_n)
        else $error("data lines driven outside a write cycle");
    chk_fault_after_ack: assert property (
        $rose(bus_fault_n) |-> transfer_ack_n)
        else $error("fault released while acknowledge still low");
    chk_stop_hold: assert property (
        s_stop_drop |-> $past(bus_fault_n))
        else $error("stop released no later than the fault");
    chk_no_new_cycle: assert property (
        strobe_n && !stop_req_n |=> strobe_n)
        else $error("cycle started while stop held");
    chk_rerun_same: assert property (
        s_rerun_start |-> addr == cyc_addr_q && write_n == cyc_write_n_q
            && (cyc_write_n_q || wdata == cyc_wdata_q))
        else $error("repeated cycle differs from the first");
    chk_rerun_prompt: assert property (
        s_stop_release |-> ##[1:8] !strobe_n)
        else $error("no repeat after stop release");
    chk_end_has_cause: assert property (
        $rose(strobe_n) |-> $past(transfer_ack_n) == 1'b0
            || $past(bus_fault_n) == 1'b0)
        else $error("cycle ended without acknowledge or fault");
    chk_wait_for_ack: assert property (
        !strobe_n && transfer_ack_n && bus_fault_n && $past(transfer_ack_n)
            && $past(bus_fault_n) |=> !strobe_n)
        else $error("cycle ended before termination was seen");
endmodule : btc_props
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench joining both termination ends back to back
`timescale 1ns/1ps
`default_nettype none
`include "btc_defines.svh"
module tb_top
    import btc_pkg::*;
();
    // ========================================
    // Signals
    logic clk, rstn;                            // Clock and reset
    logic req_valid, req_write, req_rmw;        // Cycle request
    logic [`BTC_ADDR_W-1:0] req_addr;           // Request address
    logic [`BTC_DATA_W-1:0] req_wdata;          // Request write data
    logic req_ready, rsp_done, rsp_bus_error;   // Processor status
    logic rsp_rerun, halted;                    // Processor status
    logic [`BTC_DATA_W-1:0] rsp_rdata;          // Read result
    logic cmd_valid, cmd_late, cmd_ready;       // Termination command
    btc_kind_t cmd_kind;                        // Termination kind
    logic [`BTC_HOLD_W-1:0] cmd_hold;           // Stop hold cycles
    logic [`BTC_DATA_W-1:0] cmd_rdata;          // Data to return
    logic obs_valid, obs_write;                 // Observed cycle
    logic [`BTC_ADDR_W-1:0] obs_addr;           // Observed address
    logic [`BTC_DATA_W-1:0] obs_wdata;          // Observed write data
    int err_total, check_count;                 // Verdict counters
    int obs_n, done_n, err_n, rerun_n;          // Event counts per test
    logic halt_seen, fault_bad, ready_bad;      // Flags per test
    logic [`BTC_ADDR_W-1:0] o_addr;             // Last observed address
    logic [`BTC_DATA_W-1:0] o_wdata;            // Last observed data
    logic o_write;                              // Last observed direction
    // ========================================
    // Link, both ends and checker
    btc_if bus_if ();
    btc_cpu_end btc_cpu_end_inst (.clk(clk), .rstn(rstn), .bus(bus_if),
        .req_valid(req_valid), .req_write(req_write), .req_rmw(req_rmw),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
        .rsp_done(rsp_done), .rsp_rdata(rsp_rdata), .halted(halted),
        .rsp_bus_error(rsp_bus_error), .rsp_rerun(rsp_rerun));
    btc_ext_end btc_ext_end_inst (.clk(clk), .rstn(rstn), .bus(bus_if),
        .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_late(cmd_late),
        .cmd_hold(cmd_hold), .cmd_rdata(cmd_rdata), .cmd_ready(cmd_ready),
        .obs_valid(obs_valid), .obs_addr(obs_addr), .obs_write(obs_write),
        .obs_wdata(obs_wdata));
    btc_props btc_props_inst (.clk(clk), .rstn(rstn),
        .strobe_n(bus_if.strobe_n), .write_n(bus_if.write_n),
        .rmw(bus_if.rmw), .addr(bus_if.addr), .addr_oe(bus_if.addr_oe),
        .wdata(bus_if.wdata), .data_oe(bus_if.data_oe),
        .transfer_ack_n(bus_if.transfer_ack_n),
        .bus_fault_n(bus_if.bus_fault_n), .stop_req_n(bus_if.stop_req_n),
        .rdata(bus_if.rdata));
    // Clock at 25 ns
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Counts one-cycle pulses while they stand
    always @(negedge clk) begin
        if (obs_valid === 1'b1) begin
            obs_n++;
            o_addr = obs_addr;
            o_wdata = obs_wdata;
            o_write = obs_write;
        end
        if (rsp_done === 1'b1) done_n++;
        if (rsp_rerun === 1'b1) rerun_n++;
        if (rsp_bus_error === 1'b1) begin
            err_n++;
            if (bus_if.bus_fault_n !== 1'b1) fault_bad = 1'b1;
        end
        if (halted === 1'b1) halt_seen = 1'b1;
        if (halted === 1'b1 && req_ready !== 1'b0) ready_bad = 1'b1;
    end
    // ========================================
    // Tasks
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Hands one termination to the external end
    task automatic send_cmd(input btc_kind_t k, input logic late,
                            input logic [3:0] hold, input logic [15:0] rd);
        @(negedge clk);
        cmd_kind = k;
        cmd_late = late;
        cmd_hold = hold;
        cmd_rdata = rd;
        cmd_valid = 1'b1;
        for (int i = 0; i < 200 && cmd_ready !== 1'b1; i++) @(negedge clk);
        check("cmd_ready", cmd_ready, 1'b1);
        @(negedge clk);
        cmd_valid = 1'b0;
    endtask : send_cmd
    // One processor cycle with the chosen termination
    task automatic run(input btc_kind_t k, input logic late, input logic wr,
        input logic rm, input logic [23:0] a, input logic [15:0] wd,
        input logic [15:0] rd, input logic [3:0] hold);
        logic rr;
        logic er;
        rr = (k == BTC_RERUN) && !rm;
        er = (k == BTC_BUSERR) || (k == BTC_RERUN && rm);
        {obs_n, done_n, err_n, rerun_n} = '0;
        {halt_seen, fault_bad, ready_bad} = '0;
        send_cmd(k, late, hold, rd);
        req_write = wr;
        req_rmw = rm;
        req_addr = a;
        req_wdata = wd;
        req_valid = 1'b1;
        for (int i = 0; i < 200 && req_ready !== 1'b1; i++) @(negedge clk);
        check("req_ready", req_ready, 1'b1);
        @(negedge clk);
        req_valid = 1'b0;
        for (int i = 0; i < 200 && done_n + err_n + rerun_n == 0; i++)
            @(negedge clk);
        if (rerun_n != 0) send_cmd(BTC_NORMAL, 1'b0, 4'h1, rd);
        for (int i = 0; i < 200 && done_n + err_n == 0; i++) @(negedge clk);
        for (int i = 0; i < 200 && !(req_ready === 1'b1
             && cmd_ready === 1'b1); i++) @(negedge clk);
        check("both_idle", req_ready & cmd_ready, 1'b1);
        check("done", done_n, !er);
        check("bus_error", err_n, er);
        check("rerun", rerun_n, rr);
        check("cycles", obs_n, rr ? 2 : 1);
        check("addr", o_addr, a);
        check("write", o_write, wr);
        if (wr) check("wdata", o_wdata, wd);
        else if (!er) check("rdata", rsp_rdata, rd);
        check("halted", halt_seen, k == BTC_HALT || rr);
        check("fault_at_error", fault_bad, 1'b0);
        check("ready_in_halt", ready_bad, 1'b0);
    endtask : run
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude
    // ========================================
    // Main sequence
    initial begin
        {rstn, req_valid, req_write, req_rmw, cmd_valid, cmd_late} = '0;
        {req_addr, req_wdata, cmd_hold, cmd_rdata} = '0;
        cmd_kind = BTC_NORMAL;
        {err_total, check_count} = '0;
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        run(BTC_NORMAL, 1'b0, 1'b0, 1'b0, 24'h001234, 16'h0000, 16'hA5C3,
            4'h1);
        run(BTC_NORMAL, 1'b0, 1'b1, 1'b0, 24'hFFFFFE, 16'h5A3C, 16'h0000,
            4'h1);
        run(BTC_HALT, 1'b0, 1'b0, 1'b0, 24'h00ABCD, 16'h0000, 16'h3C5A,
            4'h2);
        run(BTC_BUSERR, 1'b0, 1'b1, 1'b0, 24'h800000, 16'hFFFF, 16'h0000,
            4'h1);
        run(BTC_BUSERR, 1'b1, 1'b0, 1'b0, 24'h7FFFFF, 16'h0000, 16'h1111,
            4'h1);
        run(BTC_RERUN, 1'b0, 1'b1, 1'b0, 24'h123456, 16'hBEEF, 16'h0000,
            4'h0);
        run(BTC_RERUN, 1'b1, 1'b0, 1'b0, 24'h0F0F0E, 16'h0000, 16'hC0DE,
            4'h3);
        run(BTC_RERUN, 1'b0, 1'b0, 1'b1, 24'h000100, 16'h0000, 16'h2222,
            4'h1);
        run(BTC_NORMAL, 1'b0, 1'b1, 1'b1, 24'h000102, 16'h0F0F, 16'h0000,
            4'h1);
        conclude();
    end
    // Watchdog well beyond the nine cycles above
    initial begin
        #(25 * 20000);
        err_total++;
        conclude();
    end
endmodule : tb_top
`default_nettype wire
